// >>> bench/flash_block_access_monitor.sv
// Bus and security-mode checker for the flash block access block.
`timescale 1ns/1ps
module flash_block_access_monitor
  import flash_access_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset_n,
  // Bus and status.
  input wire wb_req_t     wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sealed_flag,
  input wire logic        full_access_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic       req;
  logic [7:0] code;
  assign req  = wb_req.cyc & wb_req.stb;
  assign code = wb_req.adr[9:2];

  ////////////////////////////////////////////////////////////////////////////
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without a request");
  chk_ack_latency: assert property (req && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("request not answered in two cycles");
  chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  chk_write_data: assert property (wb_ack_o && $past(wb_req.we) |-> wb_dat_o == 32'h0)
    else $error("write returned data");
  chk_mode_order: assert property (sealed_flag |-> full_access_flag)
    else $error("sealed while full access");
  chk_seal_cause: assert property ($changed(sealed_flag) |->
    wb_ack_o && $past(req && wb_req.we && code == IDX_CONTROL))
    else $error("sealed flag moved without control write");
  chk_full_cause: assert property ($fell(full_access_flag) |->
    wb_ack_o && $past(req && wb_req.we && code == IDX_CONTROL))
    else $error("full access entered without control write");
  chk_status_bits: assert property (wb_ack_o && $past(req && !wb_req.we && code == IDX_CONTROL)
    |-> wb_dat_o[14:13] == {full_access_flag, sealed_flag})
    else $error("status word flags wrong");
  chk_class_hidden: assert property (wb_ack_o && sealed_flag && $past(req && !wb_req.we &&
    (code == IDX_CLASS || code == IDX_SETUP)) |-> wb_dat_o == 32'h0)
    else $error("class or setup visible while sealed");
  cover property ($rose(sealed_flag));
  cover property ($fell(sealed_flag));
  cover property ($fell(full_access_flag));
endmodule

bind flash_block_access flash_block_access_monitor u_mon (
  .clk(clk), .reset_n(reset_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sealed_flag(sealed_flag), .full_access_flag(full_access_flag));

// >>> bench/flash_block_access_test.sv
// Self-checking bench for flash commit, manufacturer block and key-based modes.
`timescale 1ns/1ps
module flash_block_access_test;
  import flash_access_pkg::*;
  localparam logic [7:0]  KEY_CLS = 8'h70;
  // Key words chosen apart from the seal subcommand code.
  localparam logic [63:0] KEYS    = 64'h5678_1234_cdef_89ab;
  logic        clk;
  logic        reset_n;
  wb_req_t     wb_req;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sealed_flag;
  logic        full_access_flag;
  logic [31:0] q;
  logic [7:0]  kb [32];
  logic [7:0]  cks;
  int          miscompares;
  int          n_tests;
  int          cycles;

  flash_block_access #(.KEY_CLASS_ID(KEY_CLS)) u_dut (.clk(clk), .reset_n(reset_n),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sealed_flag(sealed_flag), .full_access_flag(full_access_flag));
  host_bus_master u_host (.clk(clk), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmp_flags(input logic s, input logic f);
    n_tests++;
    if ({sealed_flag, full_access_flag} !== {s, f}) begin
      miscompares++;
      $display("BAD %0t mode flags %b%b", $time, sealed_flag, full_access_flag);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [31:0] exp,
                        input logic [31:0] mask = 32'hffff_ffff);
    u_host.xfer(1'b0, c, 16'h0, q);
    cmp_data(q & mask, exp, "read");
  endtask
  // The whole block is rewritten so the checksum never covers unknown flash.
  task automatic fill();
    logic [7:0] s;
    s = 8'h0;
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      wr(8'(IDX_BUF_FIRST + i), {8'h0, kb[i]});
      s = s + kb[i];
    end
    cks = CHECKSUM_BASE - s;
    wr(IDX_CHECKSUM, {8'h0, cks});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_key_block();
    for (int i = 0; i < 32; i++) kb[i] = (i < 8) ? KEYS[63 - 8 * i -: 8] : 8'(i * 5);
    kb[8] = 8'ha5;
    wr(IDX_SETUP, {8'h0, SETUP_GENERAL});
    wr(IDX_CLASS, {8'h0, KEY_CLS});
    wr(IDX_BLOCK, 16'h0);
    fill();
    rd_chk(IDX_APP_STATUS, 32'ha5);
    rd_chk(8'(IDX_BUF_FIRST + 8), 32'ha5);
    wr(8'(IDX_BUF_FIRST + 8), 16'h3c);
    rd_chk(8'(IDX_BUF_FIRST + 8), 32'h3c);
    wr(IDX_CHECKSUM, {8'h0, cks});
    wr(IDX_SETUP, {8'h0, SETUP_GENERAL});
    rd_chk(8'(IDX_BUF_FIRST + 8), 32'ha5);
  endtask
  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_flags(1'b0, 1'b0);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk(IDX_APP_STATUS, 32'ha5);
  endtask
  task automatic t_mfr_sealed();
    for (int i = 0; i < 32; i++) kb[i] = 8'(i * 3 + 1);
    wr(IDX_SETUP, 16'h1);
    wr(IDX_BLOCK, {8'h0, MFR_SEL_FIRST});
    fill();
    wr(IDX_CONTROL, SEAL_SUBCMD);
    cmp_flags(1'b1, 1'b1);
    rd_chk(IDX_CONTROL, 32'h6000, 32'h6000);
    wr(IDX_CLASS, 16'h5);
    rd_chk(IDX_CLASS, 32'h0);
    rd_chk(IDX_SETUP, 32'h0);
    wr(IDX_BLOCK, {8'h0, MFR_SEL_FIRST});
    rd_chk(8'(IDX_BUF_FIRST + 5), {24'h0, kb[5]});
    wr(8'(IDX_BUF_FIRST + 5), 16'h0);
    rd_chk(8'(IDX_BUF_FIRST + 5), {24'h0, kb[5]});
  endtask
  task automatic t_keys();
    wr(IDX_CONTROL, 16'h3412);
    wr(IDX_CONTROL, 16'h0000);
    wr(IDX_CONTROL, 16'h7856);
    cmp_flags(1'b1, 1'b1);
    wr(IDX_CONTROL, 16'h3412);
    wr(IDX_CONTROL, 16'h7856);
    cmp_flags(1'b0, 1'b1);
    // Unsealed may edit the buffer but must not commit the key block.
    for (int i = 0; i < 32; i++) kb[i] = (i < 8) ? KEYS[63 - 8 * i -: 8] : 8'h11;
    wr(IDX_SETUP, {8'h0, SETUP_GENERAL});
    wr(IDX_CLASS, {8'h0, KEY_CLS});
    wr(IDX_BLOCK, 16'h0);
    fill();
    rd_chk(8'(IDX_BUF_FIRST + 8), 32'h11);
    rd_chk(IDX_APP_STATUS, 32'ha5);
    wr(IDX_CONTROL, 16'hab89);
    wr(IDX_CONTROL, 16'hefcd);
    cmp_flags(1'b0, 1'b0);
    rd_chk(IDX_CONTROL, 32'h0, 32'h6000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run needs about 430 cycles; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    miscompares = 0;
    n_tests = 0;
    cycles = 0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp_flags(1'b0, 1'b0);
    t_key_block();
    t_reset();
    t_mfr_sealed();
    t_keys();
    finish_test();
  end
endmodule

// >>> bench/host_bus_master.sv
// Host-side Wishbone master model issuing single command reads and writes.
`timescale 1ns/1ps
module host_bus_master
  import flash_access_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Bus towards the block.
  output wb_req_t          wb_req,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o
);
  initial wb_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // The request is held until ack is sampled, so a busy block only stretches it.
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] d,
                      output logic [31:0] r);
    // No local wait limit: only the bench's cycle ceiling may end a stalled transfer.
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {code, 2'b00}, sel: 4'h3, dat: {16'h0, d}};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
  endtask
endmodule

// >>> design/flash_block_access.sv
// Command-space buffer, flash commit path and key-based security modes of the gauge.
//
// Function
// - Read-only byte at 0x6a returns the stored application status flash byte.
// - Writing 0x00 to setup at 0x61 copies the selected block into the buffer.
// - Buffer holds 32 bytes at 0x40..0x5f, readable by the host and writable unless sealed.
// - Single buffer bytes can be read or rewritten by their offset alone.
// - Buffer goes to flash only after a correct block checksum written at 0x60.
// - Block select picks the 32-byte block; buffer address is 0x40 plus offset mod 32.
// - More than 32 buffer writes since the last load or commit set overflow, which blocks the commit.
// - No written value is range-checked or rejected.
// - Committed flash survives reset; reset never restores old contents.
// - A 64-byte manufacturer information area lives in flash as two 32-byte blocks.
// - Unsealed with setup 0x00, manufacturer area uses the general access procedure.
// - Sealed or setup nonzero: block select 1 or 2 loads a manufacturer block.
// - Manufacturer block commits after valid checksum; read-only when sealed.
// - Three modes; full allows all access, unsealed all but key block commits, sealed denies general flash.
// - Only full-access mode may write the transition keys.
// - Unseal and full-access transitions need two consecutive key writes; any other control write aborts.
// - Sealed flag set while sealed, cleared on the correct unseal key pair.
// - Full-access flag cleared on the correct full-access key pair.
// - Each key is two 2-byte flash words, updatable only in full-access mode.
// - Writing 0x01 to setup selects manufacturer-block selection behaviour.
// - When sealed, class select and block select cannot reach general flash.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module flash_block_access
  import flash_access_pkg::*;
#(
  parameter int         GEN_CLASSES     = 4,
  parameter int         BLOCKS_PER_CLASS = 2,
  parameter logic [7:0] MFR_CLASS_ID    = 8'h3a,
  parameter logic [7:0] KEY_CLASS_ID    = 8'h70
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Wishbone slave.
  input  wire wb_req_t     wb_req,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Security status.
  output logic             sealed_flag,
  output logic             full_access_flag
);

  localparam int GEN_BLOCKS = GEN_CLASSES * BLOCKS_PER_CLASS;
  localparam int MFR_BASE   = GEN_BLOCKS;
  localparam int KEY_BASE   = GEN_BLOCKS + 2;
  localparam int TOTAL      = GEN_BLOCKS + 3;
  localparam int IDX_W      = $clog2(TOTAL);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  mode_t                mode;
  mode_t                next_mode;
  state_t               state;
  state_t               next_state;
  key_step_t            key_step;
  key_step_t            next_key_step;
  logic [7:0]           class_select;
  logic [7:0]           next_class_select;
  logic [7:0]           block_select;
  logic [7:0]           next_block_select;
  logic [7:0]           block_access_setup;
  logic [7:0]           next_block_access_setup;
  logic [7:0]           block_checksum_byte;
  logic [7:0]           next_block_checksum_byte;
  logic [COUNT_W-1:0]   wr_count;
  logic [COUNT_W-1:0]   next_wr_count;
  logic                 overflow;
  logic                 next_overflow;
  logic [7:0]           flash_block_buffer [BLOCK_BYTES];
  logic [7:0]           next_flash_block_buffer [BLOCK_BYTES];
  logic [31:0]          next_wb_dat_o;
  logic                 next_wb_ack_o;
  logic                 next_sealed_flag;
  logic                 next_full_access_flag;

  // Flash storage: general blocks, two manufacturer blocks, one key block.
  logic [7:0]           flash_mem [TOTAL][BLOCK_BYTES];

  ////////////////////////////////////////////////////////////////////////////////
  // Target block decode.

  logic                 mfr_path;
  logic                 tgt_valid;
  logic                 tgt_is_key;
  logic [IDX_W-1:0]     tgt_idx;
  logic [15:0]          gen_idx;

  always_comb begin
    // Sealed mode always uses the manufacturer selection, so general flash is unreachable.
    mfr_path   = (mode == MODE_SEALED) || (block_access_setup != SETUP_GENERAL);
    gen_idx    = 16'(32'(class_select) * BLOCKS_PER_CLASS + 32'(block_select));
    tgt_valid  = 1'b0;
    tgt_is_key = 1'b0;
    tgt_idx    = '0;
    if (mfr_path) begin
      tgt_valid = (block_select == MFR_SEL_FIRST) || (block_select == MFR_SEL_SECOND);
      tgt_idx   = IDX_W'(MFR_BASE + int'(block_select == MFR_SEL_SECOND));
    end else if (class_select == MFR_CLASS_ID) begin
      tgt_valid = (block_select < 8'h02);
      tgt_idx   = IDX_W'(MFR_BASE + int'(block_select[0]));
    end else if (class_select == KEY_CLASS_ID) begin
      tgt_valid  = (block_select == 8'h00);
      tgt_is_key = 1'b1;
      tgt_idx    = IDX_W'(KEY_BASE);
    end else begin
      tgt_valid = (32'(class_select) < GEN_CLASSES) && (32'(block_select) < BLOCKS_PER_CLASS);
      tgt_idx   = IDX_W'(gen_idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checksum and keys.

  logic [7:0]  data_sum;
  logic [15:0] unseal_key0_sw;
  logic [15:0] unseal_key1_sw;
  logic [15:0] full_key0_sw;
  logic [15:0] full_key1_sw;

  always_comb begin
    data_sum = 8'h00;
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      data_sum = data_sum + flash_block_buffer[i];
    end
  end

  // The host sends each key word byte-swapped relative to the stored order.
  always_comb begin
    unseal_key0_sw = {flash_mem[KEY_BASE][UNSEAL_KEY0_OFS+1], flash_mem[KEY_BASE][UNSEAL_KEY0_OFS]};
    unseal_key1_sw = {flash_mem[KEY_BASE][UNSEAL_KEY1_OFS+1], flash_mem[KEY_BASE][UNSEAL_KEY1_OFS]};
    full_key0_sw   = {flash_mem[KEY_BASE][FULL_KEY0_OFS+1], flash_mem[KEY_BASE][FULL_KEY0_OFS]};
    full_key1_sw   = {flash_mem[KEY_BASE][FULL_KEY1_OFS+1], flash_mem[KEY_BASE][FULL_KEY1_OFS]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic                 req;
  logic                 wr;
  logic                 wr_byte;
  logic                 wr_word;
  logic [7:0]           idx;
  logic [7:0]           wbyte;
  logic [15:0]          wword;
  logic                 idx_buf;
  logic [BUF_OFS_W-1:0] buf_ofs;

  always_comb begin
    req     = wb_req.cyc && wb_req.stb && !wb_ack_o && (state == ST_IDLE);
    wr      = req && wb_req.we;
    wr_byte = wr && wb_req.sel[0];
    wr_word = wr && (wb_req.sel[1:0] == 2'b11);
    idx     = wb_req.adr[ADR_W-1:2];
    wbyte   = wb_req.dat[7:0];
    wword   = wb_req.dat[15:0];
    idx_buf = (idx >= IDX_BUF_FIRST) && (idx <= IDX_BUF_LAST);
    buf_ofs = idx[BUF_OFS_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic commit_ok;

  always_comb begin
    next_mode                = mode;
    next_state               = state;
    next_key_step            = key_step;
    next_class_select        = class_select;
    next_block_select        = block_select;
    next_block_access_setup  = block_access_setup;
    next_block_checksum_byte = block_checksum_byte;
    next_wr_count            = wr_count;
    next_overflow            = overflow;
    next_flash_block_buffer  = flash_block_buffer;
    next_wb_ack_o            = req;
    next_wb_dat_o            = 32'h0000_0000;
    // A commit needs a full block's correct checksum and the right permissions.
    commit_ok = tgt_valid && !overflow && (mode != MODE_SEALED)
             && (wbyte == CHECKSUM_BASE - data_sum)
             && (!tgt_is_key || mode == MODE_FULL);

    case (state)
      ST_IDLE: begin
        if (wr_byte && idx_buf && mode != MODE_SEALED) begin
          // Stored as given; a single offset write touches only that byte.
          next_flash_block_buffer[buf_ofs] = wbyte;
          if (wr_count > COUNT_W'(BLOCK_BYTES - 1)) begin
            next_overflow = 1'b1;
          end else begin
            next_wr_count = wr_count + COUNT_W'(1);
          end
        end
        if (wr_byte && idx == IDX_CLASS && mode != MODE_SEALED) begin
          next_class_select = wbyte;
        end
        if (wr_byte && idx == IDX_BLOCK) begin
          next_block_select = wbyte;
          next_state        = ST_LOAD;
        end
        if (wr_byte && idx == IDX_SETUP && mode != MODE_SEALED) begin
          next_block_access_setup = wbyte;
          next_state              = ST_LOAD;
        end
        if (wr_byte && idx == IDX_CHECKSUM) begin
          next_block_checksum_byte = wbyte;
          if (commit_ok) begin
            next_state = ST_COMMIT;
          end
        end
        if (wr_word && idx == IDX_CONTROL) begin
          // Any control write that is not the expected second key aborts a pending pair.
          next_key_step = KEY_NONE;
          if (key_step == KEY_UNSEAL_HALF && wword == unseal_key0_sw
              && mode == MODE_SEALED) begin
            next_mode = MODE_UNSEALED;
          end else if (key_step == KEY_FULL_HALF && wword == full_key0_sw
                       && mode == MODE_UNSEALED) begin
            next_mode = MODE_FULL;
          end else if (wword == unseal_key1_sw && mode == MODE_SEALED) begin
            next_key_step = KEY_UNSEAL_HALF;
          end else if (wword == full_key1_sw && mode == MODE_UNSEALED) begin
            next_key_step = KEY_FULL_HALF;
          end else if (wword == SEAL_SUBCMD && mode != MODE_SEALED) begin
            next_mode = MODE_SEALED;
          end
        end
        if (req && !wb_req.we) begin
          if (idx_buf) begin
            next_wb_dat_o = {24'h00_0000, flash_block_buffer[buf_ofs]};
          end else if (idx == IDX_CONTROL) begin
            next_wb_dat_o[SEALED_BIT]      = sealed_flag;
            next_wb_dat_o[FULL_ACCESS_BIT] = full_access_flag;
          end else if (idx == IDX_CLASS && mode != MODE_SEALED) begin
            next_wb_dat_o = {24'h00_0000, class_select};
          end else if (idx == IDX_BLOCK) begin
            next_wb_dat_o = {24'h00_0000, block_select};
          end else if (idx == IDX_CHECKSUM) begin
            next_wb_dat_o = {24'h00_0000, block_checksum_byte};
          end else if (idx == IDX_SETUP && mode != MODE_SEALED) begin
            next_wb_dat_o = {24'h00_0000, block_access_setup};
          end else if (idx == IDX_APP_STATUS) begin
            next_wb_dat_o = {24'h00_0000, flash_mem[KEY_BASE][APP_STATUS_OFS]};
          end
        end
      end
      ST_LOAD: begin
        for (int i = 0; i < BLOCK_BYTES; i++) begin
          next_flash_block_buffer[i] = tgt_valid ? flash_mem[tgt_idx][i] : 8'h00;
        end
        next_wr_count = '0;
        next_overflow = 1'b0;
        next_state    = ST_IDLE;
      end
      ST_COMMIT: begin
        next_wr_count = '0;
        next_state    = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    next_sealed_flag      = (next_mode == MODE_SEALED);
    next_full_access_flag = (next_mode != MODE_FULL);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode                <= MODE_FULL;
      state               <= ST_IDLE;
      key_step            <= KEY_NONE;
      class_select        <= 8'h00;
      block_select        <= 8'h00;
      block_access_setup  <= SETUP_GENERAL;
      block_checksum_byte <= 8'h00;
      wr_count            <= '0;
      overflow            <= 1'b0;
      wb_dat_o            <= 32'h0000_0000;
      wb_ack_o            <= 1'b0;
      sealed_flag         <= 1'b0;
      full_access_flag    <= 1'b0;
      for (int i = 0; i < BLOCK_BYTES; i++) begin
        flash_block_buffer[i] <= 8'h00;
      end
    end else begin
      mode                <= next_mode;
      state               <= next_state;
      key_step            <= next_key_step;
      class_select        <= next_class_select;
      block_select        <= next_block_select;
      block_access_setup  <= next_block_access_setup;
      block_checksum_byte <= next_block_checksum_byte;
      wr_count            <= next_wr_count;
      overflow            <= next_overflow;
      wb_dat_o            <= next_wb_dat_o;
      wb_ack_o            <= next_wb_ack_o;
      sealed_flag         <= next_sealed_flag;
      full_access_flag    <= next_full_access_flag;
      flash_block_buffer  <= next_flash_block_buffer;
    end
  end

  // Flash cells deliberately have no reset so committed data survives it.
  always_ff @(posedge clk) begin
    if (state == ST_COMMIT) begin
      for (int i = 0; i < BLOCK_BYTES; i++) begin
        flash_mem[tgt_idx][i] <= flash_block_buffer[i];
      end
    end
  end

endmodule

// >>> pkg/flash_access_pkg.sv
// Shared constants, enumerations and carrier types of the flash block access block.
package flash_access_pkg;

  // Bus geometry: each command code occupies one aligned 32-bit word.
  localparam int ADR_W = 10;
  localparam int BLOCK_BYTES = 32;
  localparam int BUF_OFS_W = 5;
  localparam int COUNT_W = 6;

  // Command codes, used as word indexes; byte address is four times the code.
  localparam logic [7:0] IDX_CONTROL    = 8'h00;
  localparam logic [7:0] IDX_CLASS      = 8'h3e;
  localparam logic [7:0] IDX_BLOCK      = 8'h3f;
  localparam logic [7:0] IDX_BUF_FIRST  = 8'h40;
  localparam logic [7:0] IDX_BUF_LAST   = 8'h5f;
  localparam logic [7:0] IDX_CHECKSUM   = 8'h60;
  localparam logic [7:0] IDX_SETUP      = 8'h61;
  localparam logic [7:0] IDX_APP_STATUS = 8'h6a;

  // Setup values and manufacturer block selectors.
  localparam logic [7:0] SETUP_GENERAL  = 8'h00;
  localparam logic [7:0] MFR_SEL_FIRST  = 8'h01;
  localparam logic [7:0] MFR_SEL_SECOND = 8'h02;
  localparam logic [7:0] CHECKSUM_BASE  = 8'hff;

  // Control status word layout.
  localparam int SEALED_BIT      = 13;
  localparam int FULL_ACCESS_BIT = 14;
  localparam logic [15:0] SEAL_SUBCMD = 16'h0020;

  // Byte positions inside the key block of flash.
  localparam int UNSEAL_KEY0_OFS = 0;
  localparam int UNSEAL_KEY1_OFS = 2;
  localparam int FULL_KEY0_OFS   = 4;
  localparam int FULL_KEY1_OFS   = 6;
  localparam int APP_STATUS_OFS  = 8;

  typedef enum logic [1:0] {
    MODE_FULL     = 2'b00,
    MODE_UNSEALED = 2'b01,
    MODE_SEALED   = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOAD   = 2'b01,
    ST_COMMIT = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    KEY_NONE        = 2'b00,
    KEY_UNSEAL_HALF = 2'b01,
    KEY_FULL_HALF   = 2'b10
  } key_step_t;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_t;

endpackage
